/* File: common/prog_seq_pkg.sv */
// Constants and types of the program sequencer
package prog_seq_pkg;
    // ****************************************
    // Widths
    // ****************************************
    localparam int PC_W      = 15;
    localparam int BANK_W    = 2;
    localparam int PAGE_W    = 13;
    localparam int BYTE_W    = 8;
    localparam int INSTR_W   = 16;
    localparam int ADDR_W    = 8;
    localparam int STK_DEPTH = 8;
    // ****************************************
    // Register offsets and fields
    // ****************************************
    localparam logic [ADDR_W-1:0] ADDR_PCL    = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_BANK   = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;
    localparam int STAT_FULL_BIT  = 16;
    localparam int STAT_PHASE_LSB = 20;
    // ****************************************
    // Reset values and counter step
    // ****************************************
    localparam logic [PC_W-1:0]   PC_RESET     = 15'h0000;
    localparam logic [PC_W-1:0]   PC_ONE       = 15'h0001;
    localparam logic [BANK_W-1:0] BANK_RESET   = 2'h0;
    localparam logic [3:0]        PHASES_RESET = 4'h1;
    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        PH_T1 = 2'b00,
        PH_T2 = 2'b01,
        PH_T3 = 2'b10,
        PH_T4 = 2'b11
    } phase_t;
    typedef enum logic [2:0] {
        OP_NONE              = 3'b000,
        JUMP_OP              = 3'b001,
        CALL_OP              = 3'b010,
        SUBROUTINE_RETURN_OP = 3'b011,
        INTERRUPT_RETURN_OP  = 3'b100,
        SKIP_OP              = 3'b101,
        PCL_WRITE_OP         = 3'b110
    } seq_op_t;
endpackage : prog_seq_pkg

/* File: rtl/program_sequencer.sv */
// Program sequencer: phases, program counter, return stack, bus slave
//
// Summary of operation
// - Four phases form one instruction cycle
// - Counter advances and fetch starts at first phase
// - Fetch of next overlaps current execution
// - Counter-changing instruction costs one extra cycle
// - Counter increments by one unless redirected
// - Bank field forms high program address bits
// - Software writes only counter low byte; status register reads whole counter
// - Jumps, calls, interrupts, reset load destination
// - Taken skip discards fetched word, dummy cycle
// - Low byte write jumps within page, dummy
// - Stack hidden, holds only counter values
// - Call/interrupt push, returns restore counter
// - Reset sets stack pointer to top
// - Full stack withholds acknowledge until return
// - Call on full stack loses oldest entry
// - Reset sets program counter to zero
`timescale 1ns/1ps
module program_sequencer import prog_seq_pkg::*; #(
    parameter int STACK_LEVELS = STK_DEPTH
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               resetn,
    // AHB-Lite slave
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic                    hreadyout,
    output logic [31:0]             hrdata,
    output logic                    hresp,
    // Program memory
    output logic [PC_W-1:0]         pm_addr,
    output logic                    pm_fetch,
    input  wire logic [INSTR_W-1:0] pm_rdata,
    // Instruction decoder
    output logic [INSTR_W-1:0]      instr,
    output logic                    instr_valid,
    input  wire logic [2:0]         dec_op,
    input  wire logic [PAGE_W-1:0]  dec_target,
    // Interrupt logic
    input  wire logic               irq_req,
    input  wire logic [PC_W-1:0]    irq_vector,
    output logic                    irq_ack,
    // Phase outputs
    output logic [3:0]              cycle_phases
);
    localparam int SP_W = $clog2(STACK_LEVELS);
    localparam logic [SP_W:0] STK_FULL_CNT = (SP_W+1)'(STACK_LEVELS);
    localparam logic [SP_W:0] STK_CNT_ONE  = (SP_W+1)'(1);
    localparam logic [SP_W-1:0] SP_ONE     = SP_W'(1);

    // ****************************************
    // State
    // ****************************************
    phase_t                phase_q;
    logic [3:0]            phases_q;
    logic [PC_W-1:0]       pc_q;
    logic [PC_W-1:0]       exec_pc_q;
    logic [INSTR_W-1:0]    instr_q;
    logic                  valid_q;
    logic                  fetch_q;
    logic                  ack_q;
    logic [BANK_W-1:0]     bank_q;
    logic                  pcl_req_q;
    logic [BYTE_W-1:0]     pcl_data_q;
    logic [PC_W-1:0]       stack_q [STACK_LEVELS];
    logic [SP_W-1:0]       head_q;
    logic [SP_W:0]         cnt_q;
    logic                  wr_act_q;
    logic [ADDR_W-1:0]     wr_addr_q;
    logic [31:0]           rdata_q;
    logic                  ready_q;

    // ****************************************
    // Phase generator
    // ****************************************
    phase_t phase_d;
    always_comb begin
        case (phase_q)
            PH_T1:   phase_d = PH_T2;
            PH_T2:   phase_d = PH_T3;
            PH_T3:   phase_d = PH_T4;
            PH_T4:   phase_d = PH_T1;
            default: phase_d = PH_T1;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phase_q  <= PH_T1;
            phases_q <= PHASES_RESET;
        end else begin
            phase_q  <= phase_d;
            phases_q <= {phases_q[2:0], phases_q[3]};
        end
    end

    // ****************************************
    // Sequencing decisions
    // ****************************************
    wire           at_t4      = (phase_q == PH_T4);
    wire seq_op_t  op_live    = valid_q ? seq_op_t'(dec_op) : OP_NONE;
    wire           stk_full   = (cnt_q == STK_FULL_CNT);
    wire           stk_empty  = (cnt_q == '0);
    wire [PC_W-1:0] stk_top   = stack_q[head_q];
    wire           is_ret     = (op_live == SUBROUTINE_RETURN_OP) ||
                                (op_live == INTERRUPT_RETURN_OP);
    wire           pcl_take   = pcl_req_q && (op_live == OP_NONE);
    wire           irq_take   = irq_req && !stk_full && !pcl_take &&
                                (op_live == OP_NONE);
    wire           do_push    = at_t4 &&
                                ((op_live == CALL_OP) || irq_take);
    wire           do_pop     = at_t4 && is_ret;
    wire [PC_W-1:0] far_tgt   = {bank_q, dec_target};
    wire [PC_W-1:0] page_tgt  = {exec_pc_q[PC_W-1:BYTE_W],
                                 dec_target[BYTE_W-1:0]};
    wire [PC_W-1:0] swpcl_tgt = {exec_pc_q[PC_W-1:BYTE_W], pcl_data_q};

    logic [PC_W-1:0] pc_d;
    logic            flush;
    always_comb begin
        pc_d  = pc_q + PC_ONE;
        flush = 1'b0;
        case (op_live)
            JUMP_OP, CALL_OP: begin
                pc_d  = far_tgt;
                flush = 1'b1;
            end
            SUBROUTINE_RETURN_OP, INTERRUPT_RETURN_OP: begin
                pc_d  = stk_top;
                flush = 1'b1;
            end
            SKIP_OP: begin
                flush = 1'b1;
            end
            PCL_WRITE_OP: begin
                pc_d  = page_tgt;
                flush = 1'b1;
            end
            default: begin
                if (pcl_take) begin
                    pc_d  = swpcl_tgt;
                    flush = 1'b1;
                end else if (irq_take) begin
                    pc_d  = irq_vector;
                    flush = 1'b1;
                end
            end
        endcase
    end

    // ****************************************
    // Program counter and fetch pipeline
    // ****************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pc_q      <= PC_RESET;
            exec_pc_q <= PC_RESET;
            instr_q   <= '0;
            valid_q   <= 1'b0;
            fetch_q   <= 1'b0;
            ack_q     <= 1'b0;
        end else begin
            fetch_q <= at_t4;
            ack_q   <= at_t4 && irq_take;
            if (at_t4) begin
                pc_q      <= pc_d;
                exec_pc_q <= pc_q;
                instr_q   <= pm_rdata;
                valid_q   <= !flush;
            end
        end
    end

    // ****************************************
    // Return stack
    // ****************************************
    always_ff @(posedge clk) begin
        if (do_push) begin
            stack_q[head_q + SP_ONE] <= pc_q;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            head_q <= '1;
            cnt_q  <= '0;
        end else if (do_push) begin
            head_q <= head_q + SP_ONE;
            if (!stk_full) begin
                cnt_q <= cnt_q + STK_CNT_ONE;
            end
        end else if (do_pop) begin
            head_q <= head_q - SP_ONE;
            if (!stk_empty) begin
                cnt_q <= cnt_q - STK_CNT_ONE;
            end
        end
    end

    // ****************************************
    // Bus slave
    // ****************************************
    wire        ahb_take = hsel && htrans[1] && hready;
    wire        wr_pcl   = wr_act_q && (wr_addr_q == ADDR_PCL);
    wire        wr_bank  = wr_act_q && (wr_addr_q == ADDR_BANK);
    wire [31:0] rd_pcl   = {24'h000000, exec_pc_q[BYTE_W-1:0]};
    wire [31:0] rd_bank  = {30'h0, bank_q};
    wire [31:0] rd_stat  = 32'(exec_pc_q) |
                           (32'(stk_full) << STAT_FULL_BIT) |
                           (32'(phase_q) << STAT_PHASE_LSB);
    wire [31:0] rd_mux   = (haddr[ADDR_W-1:0] == ADDR_PCL)    ? rd_pcl  :
                           (haddr[ADDR_W-1:0] == ADDR_BANK)   ? rd_bank :
                           (haddr[ADDR_W-1:0] == ADDR_STATUS) ? rd_stat :
                           32'h00000000;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_act_q  <= 1'b0;
            wr_addr_q <= '0;
            rdata_q   <= 32'h00000000;
            ready_q   <= 1'b1;
        end else begin
            ready_q  <= 1'b1;
            wr_act_q <= ahb_take && hwrite;
            if (ahb_take) begin
                wr_addr_q <= haddr[ADDR_W-1:0];
            end
            if (ahb_take && !hwrite) begin
                rdata_q <= rd_mux;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bank_q     <= BANK_RESET;
            pcl_req_q  <= 1'b0;
            pcl_data_q <= '0;
        end else begin
            if (wr_bank) begin
                bank_q <= hwdata[BANK_W-1:0];
            end
            if (wr_pcl) begin
                pcl_req_q  <= 1'b1;
                pcl_data_q <= hwdata[BYTE_W-1:0];
            end else if (at_t4 && pcl_take) begin
                pcl_req_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign hreadyout    = ready_q;
    assign hrdata       = rdata_q;
    assign hresp        = 1'b0;
    assign pm_addr      = pc_q;
    assign pm_fetch     = fetch_q;
    assign instr        = instr_q;
    assign instr_valid  = valid_q;
    assign irq_ack      = ack_q;
    assign cycle_phases = phases_q;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence seq_dummy;
        !valid_q [*4];
    endsequence

    sequence seq_no_fetch;
        !fetch_q [*3];
    endsequence

    a_phase_ring: assert property (
        1'b1 |=> $onehot(phases_q) &&
            (phases_q == {$past(phases_q[2:0]), $past(phases_q[3])}))
        else $error("phase ring broken");

    a_fetch_t1: assert property (
        at_t4 |=> fetch_q ##1 seq_no_fetch)
        else $error("fetch not once per cycle at first phase");

    a_pc_step: assert property (
        at_t4 && !flush |=> pc_q == $past(pc_q) + PC_ONE)
        else $error("counter did not step by one");

    a_jump_dummy: assert property (
        at_t4 && op_live == JUMP_OP |=>
            (pc_q == {$past(bank_q), $past(dec_target)}) and seq_dummy)
        else $error("jump target or dummy cycle wrong");

    a_skip_dummy: assert property (
        at_t4 && op_live == SKIP_OP |=>
            (pc_q == $past(pc_q) + PC_ONE) and seq_dummy)
        else $error("skip did not discard fetched word");

    a_pcl_page: assert property (
        at_t4 && pcl_take |=>
            ((pc_q[PC_W-1:BYTE_W] == $past(exec_pc_q[PC_W-1:BYTE_W])) &&
            (pc_q[BYTE_W-1:0] == $past(pcl_data_q))) and seq_dummy)
        else $error("low byte write left the page");

    a_call_ret: assert property (
        at_t4 && op_live == CALL_OP ##8 at_t4 && op_live ==
            SUBROUTINE_RETURN_OP |=> pc_q == $past(pc_q, 9))
        else $error("return did not restore pushed counter");

    a_irq_full: assert property (
        at_t4 && stk_full |=> !irq_ack)
        else $error("acknowledge while stack full");

    a_call_ovf: assert property (
        at_t4 && stk_full && op_live == CALL_OP |=>
            stk_full && head_q == $past(head_q) + SP_ONE)
        else $error("call on full stack mishandled");
endmodule : program_sequencer

/* File: dv/prog_mem_model.sv */
// Program memory model feeding fetched words to the sequencer
`timescale 1ns/1ps
module prog_mem_model import prog_seq_pkg::*; (
    // Clock
    input  wire logic               clk,
    // Fetch port
    input  wire logic [PC_W-1:0]    pm_addr,
    input  wire logic               pm_fetch,
    output logic [INSTR_W-1:0]      pm_rdata
);
    // ****************************************
    // Registered read, one clock after the address
    // ****************************************
    always_ff @(posedge clk) begin
        pm_rdata <= {~pm_fetch | pm_fetch, pm_addr};
    end
endmodule : prog_mem_model

/* File: dv/program_sequencer_pc_stack_tb_top.sv */
// Testbench of the program sequencer
`timescale 1ns/1ps
module program_sequencer_pc_stack_tb_top import prog_seq_pkg::*;;
    logic clk = 0, resetn = 0, hsel = 0, hwrite = 0, irq_req = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic [1:0]  htrans = 0;
    logic [2:0]  hsize = 3'h2, dec_op = 0;
    logic hreadyout, hresp, pm_fetch, instr_valid, irq_ack;
    logic [PC_W-1:0] pm_addr, t4_pc, r[1:6], p;
    logic [INSTR_W-1:0] pm_rdata, instr;
    logic [PAGE_W-1:0] dec_target = 0;
    logic [3:0] cycle_phases;
    logic [31:0] rd;
    localparam logic [PC_W-1:0] VEC = 15'h0040;
    int n_errors = 0, n_checks = 0, n_ack = 0, k;
    always #2.5 clk = ~clk;
    program_sequencer #(.STACK_LEVELS(4)) i_dut (.clk(clk), .resetn(resetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .pm_addr(pm_addr), .pm_fetch(pm_fetch), .pm_rdata(pm_rdata),
        .instr(instr), .instr_valid(instr_valid), .dec_op(dec_op),
        .dec_target(dec_target), .irq_req(irq_req), .irq_vector(VEC),
        .irq_ack(irq_ack), .cycle_phases(cycle_phases));
    prog_mem_model i_mem (.clk(clk), .pm_addr(pm_addr),
        .pm_fetch(pm_fetch), .pm_rdata(pm_rdata));
    always @(posedge clk) begin
        if (cycle_phases === 4'h8) t4_pc = pm_addr;
        if (irq_ack === 1'b1) n_ack++;
    end
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] s, e);
        n_checks++;
        if (s !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish
    task automatic hang;
        n_errors++;
        tally_and_finish();
    endtask : hang
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int i;
        htrans <= 2'h2;
        hsel   <= 1'b1;
        hwrite <= w;
        haddr  <= {24'h0, a};
        for (i = 0; i < 40; i++) begin
            @(posedge clk);
            if (hreadyout === 1'b1) break;
        end
        if (i == 40) hang();
        htrans <= 2'h0;
        hwdata <= d;
        for (i = 0; i < 40; i++) begin
            @(posedge clk);
            if (hreadyout === 1'b1) break;
        end
        if (i == 40) hang();
        q = hrdata;
        chk("hresp", 32'(hresp), 32'h0);
    endtask : ahb
    task automatic do_op(input logic [2:0] op, input logic [12:0] t,
                         output logic [PC_W-1:0] ret);
        int i;
        for (i = 0; i < 40; i++) begin
            @(posedge clk);
            if (cycle_phases === 4'h4 && instr_valid === 1'b1) break;
        end
        if (i == 40) hang();
        dec_op <= op;
        dec_target <= t;
        @(posedge clk);
        ret = pm_addr;
        dec_op <= OP_NONE;
        #1;
    endtask : do_op
    task automatic wait_ack;
        int i;
        for (i = 0; i < 40 && irq_ack !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        if (i == 40) hang();
    endtask : wait_ack
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        #1;
        chk("phases_rst", 32'(cycle_phases), 32'h1);
        chk("pc_rst", 32'(pm_addr), 32'h0);
        for (k = 1; k <= 4; k++) begin
            @(posedge clk);
            #1;
            chk("phases", 32'(cycle_phases), 32'(4'h1 << (k % 4)));
        end
        ahb(1'b0, 8'h08, 0, rd);
        chk("full_rst", 32'(rd[STAT_FULL_BIT]), 0);
        ahb(1'b0, 8'h0C, 0, rd);
        chk("unmapped", rd, 0);
        do_op(JUMP_OP, 13'h0140, p);
        chk("jmp_pc", 32'(pm_addr), 32'h0140);
        chk("jmp_dummy", 32'(instr_valid), 0);
        repeat (4) @(posedge clk);
        #1;
        chk("instr", 32'(instr), 32'h8140);
        chk("seq_pc", 32'(pm_addr), 32'h0141);
        repeat (4) @(posedge clk);
        #1;
        chk("pm_fetch", 32'(pm_fetch), 1);
        chk("seq_pc2", 32'(pm_addr), 32'h0142);
        ahb(1'b1, ADDR_PCL, 32'h5A, rd);
        for (k = 0; k < 40 && instr_valid !== 1'b0; k++) @(posedge clk);
        if (k == 40) hang();
        #1;
        chk("pcl_jmp", 32'(pm_addr), 32'h015A);
        ahb(1'b1, ADDR_BANK, 32'h2, rd);
        ahb(1'b0, ADDR_BANK, 0, rd);
        chk("bank_rd", rd & 32'h3, 32'h2);
        ahb(1'b0, ADDR_PCL, 0, rd);
        chk("pcl_rd", rd, 32'h5A);
        do_op(JUMP_OP, 13'h0123, p);
        chk("bank_jmp", 32'(pm_addr), 32'h4123);
        do_op(SKIP_OP, 0, p);
        chk("skip_dummy", 32'(instr_valid), 0);
        for (k = 1; k <= 4; k++) do_op(CALL_OP, 13'(k * 16), r[k]);
        chk("call_pc", 32'(pm_addr), 32'h4040);
        ahb(1'b0, ADDR_STATUS, 0, rd);
        chk("full", 32'(rd[STAT_FULL_BIT]), 1);
        irq_req <= 1'b1;
        repeat (16) @(posedge clk);
        chk("no_ack", n_ack, 0);
        do_op(SUBROUTINE_RETURN_OP, 0, p);
        chk("ret_pc", 32'(pm_addr), 32'(r[4]));
        wait_ack();
        p = t4_pc;
        irq_req <= 1'b0;
        chk("irq_pc", 32'(pm_addr), 32'(VEC));
        do_op(INTERRUPT_RETURN_OP, 0, r[4]);
        chk("iret_pc", 32'(pm_addr), 32'(p));
        do_op(CALL_OP, 13'h0100, r[5]);
        do_op(CALL_OP, 13'h0180, r[6]);
        for (k = 6; k >= 2; k--) begin
            if (k == 4) continue;
            do_op(SUBROUTINE_RETURN_OP, 0, p);
            chk("ovf_ret", 32'(pm_addr), 32'(r[k]));
        end
        tally_and_finish();
    end
    initial begin
        #100000;
        hang();
    end
endmodule : program_sequencer_pc_stack_tb_top
